// file: mdm_cfg.svh
// constants for the serial management port slave
//
// How it works
// - receiver samples data line on rising clock
// - line left undriven while idle
// - strap address captured at reset, frames matched
// - silent on frames for other devices
// - register field selects one of 32 words
// - frame begins with 01 after high idle
// - two turnaround bits before data field
// - read drives zero, then 16 data bits
// - direct access covers addresses 0x00 to 0x1F except 0x0E, the window
// - control bits 15:14 select address/data function
// - control bits 4:0 pick target space
`ifndef MDM_CFG_SVH
`define MDM_CFG_SVH

// ------------------------------------------------------------
// frame layout
// ------------------------------------------------------------
`define MDM_OP_READ 2'h2
`define MDM_OP_WRITE 2'h1
`define MDM_LAST_OP 4'h1
`define MDM_LAST_ADDR 4'h4
`define MDM_LAST_TA 4'h1
`define MDM_LAST_DATA 4'hF
`define MDM_PHY_HI 2'h0

// ------------------------------------------------------------
// direct register offsets and reset values
// ------------------------------------------------------------
`define MDM_IDX_CTRL 5'h0D
`define MDM_IDX_ADDR_DATA 5'h0E
`define MDM_REG_RESET 16'h0000
`define MDM_EXT_ADDR_RESET 16'h0000

// ------------------------------------------------------------
// indirect access control fields
// ------------------------------------------------------------
`define MDM_FN_HI 15
`define MDM_FN_LO 14
`define MDM_SEL_HI 4
`define MDM_SEL_LO 0
`define MDM_FN_ADDR 2'h0
`define MDM_FN_DATA 2'h1
`define MDM_FN_INC_RW 2'h2
`define MDM_FN_INC_WR 2'h3
`define MDM_SEL_VEND 5'h1F
`define MDM_SEL_PMA 5'h01
`define MDM_SEL_V3 5'h03
`define MDM_SEL_V7 5'h07

`endif

// file: mdm_pkg.sv
// types for the serial management port slave
package mdm_pkg;

    // ------------------------------------------------------------
    // frame parser states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MDM_HUNT,   // waiting for a high idle bit
        MDM_IDLE,   // idle seen, waiting for start 0
        MDM_START,  // start 0 seen, expect 1
        MDM_OP,
        MDM_PHY,
        MDM_REG,
        MDM_TA,
        MDM_DATA
    } mdm_state_t;

    // ------------------------------------------------------------
    // complete state of the slave
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] mdc_sync;        // clock pin synchroniser
        logic [1:0] mdio_sync;       // data pin synchroniser
        logic [1:0][2:0] strap_sync; // strap pin synchroniser
        logic mdc_prev;              // for rising edge detect
        logic [2:0] phy_addr;        // captured strap address
        mdm_state_t state;
        logic [3:0] cnt;             // bit count within field
        logic [1:0] op;
        logic [4:0] phy;
        logic [4:0] reg_addr;
        logic [15:0] shift;          // data in or out
        logic drive;                 // output enable
        logic out_bit;               // bit on the line
        logic [31:0][15:0] regs;     // directly reachable words
        logic [15:0] ext_addr;       // extended address register
        logic [15:0][15:0] ext;      // extended storage window
    } mdm_regs_t;

endpackage

// file: mdm_slave.sv
// serial management port slave: frame parser, direct and indirect registers
`timescale 1ns/100ps
`include "mdm_cfg.svh"

module mdm_slave (
    // system
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // management link from the station
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    // address straps
    input wire logic [2:0] phy_strap_i
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    mdm_pkg::mdm_regs_t q;   // registered state
    mdm_pkg::mdm_regs_t n;   // next state

    // ------------------------------------------------------------
    // next state logic
    // ------------------------------------------------------------
    always_comb begin
        logic rise;          // link clock rising edge seen
        logic bit_in;        // line level at that edge
        logic match;         // frame is for this device
        logic sel_ok;        // target space supported
        logic [1:0] fn;      // indirect function
        logic [3:0] eidx;    // extended storage index
        logic [15:0] wdata;  // complete write word
        logic [15:0] rdata;  // word to send on a read
        rise = 1'b0;
        bit_in = 1'b0;
        match = 1'b0;
        sel_ok = 1'b0;
        fn = 2'h0;
        eidx = 4'h0;
        wdata = 16'h0000;
        rdata = 16'h0000;
        n = q;
        // synchronisers, first stage read only by the second
        n.mdc_sync = {q.mdc_sync[0], mdc_i};
        n.mdio_sync = {q.mdio_sync[0], mdio_i};
        n.strap_sync = {q.strap_sync[0], phy_strap_i};
        n.mdc_prev = q.mdc_sync[1];
        // the clock may stop between frames; only edges move us
        rise = q.mdc_sync[1] & ~q.mdc_prev;
        bit_in = q.mdio_sync[1];
        match = (q.phy == {`MDM_PHY_HI, q.phy_addr});
        fn = q.regs[`MDM_IDX_CTRL][`MDM_FN_HI:`MDM_FN_LO];
        eidx = q.ext_addr[3:0];
        // only four target spaces answer indirect access
        case (q.regs[`MDM_IDX_CTRL][`MDM_SEL_HI:`MDM_SEL_LO])
            `MDM_SEL_VEND, `MDM_SEL_PMA, `MDM_SEL_V3, `MDM_SEL_V7: begin
                sel_ok = 1'b1;
            end
            default: begin
                sel_ok = 1'b0;
            end
        endcase
        wdata = {q.shift[14:0], bit_in};

        if (rise) begin
            case (q.state)
                // need a high bit before a start is believed
                mdm_pkg::MDM_HUNT: begin
                    if (bit_in) begin
                        n.state = mdm_pkg::MDM_IDLE;
                    end
                end
                // idle high, line released by us
                mdm_pkg::MDM_IDLE: begin
                    if (!bit_in) begin
                        n.state = mdm_pkg::MDM_START;
                    end
                end
                // second start bit must be 1
                mdm_pkg::MDM_START: begin
                    n.cnt = 4'h0;
                    n.state = bit_in ? mdm_pkg::MDM_OP : mdm_pkg::MDM_HUNT;
                end
                // two bit operation code
                mdm_pkg::MDM_OP: begin
                    n.op = {q.op[0], bit_in};
                    n.cnt = q.cnt + 4'h1;
                    if (q.cnt == `MDM_LAST_OP) begin
                        n.cnt = 4'h0;
                        // unknown codes are not answered at all
                        if (n.op == `MDM_OP_READ || n.op == `MDM_OP_WRITE) begin
                            n.state = mdm_pkg::MDM_PHY;
                        end else begin
                            n.state = mdm_pkg::MDM_HUNT;
                        end
                    end
                end
                // five bit device address, MSB first
                mdm_pkg::MDM_PHY: begin
                    n.phy = {q.phy[3:0], bit_in};
                    n.cnt = q.cnt + 4'h1;
                    if (q.cnt == `MDM_LAST_ADDR) begin
                        n.cnt = 4'h0;
                        n.state = mdm_pkg::MDM_REG;
                    end
                end
                // five bit register address, read word fetched here
                mdm_pkg::MDM_REG: begin
                    n.reg_addr = {q.reg_addr[3:0], bit_in};
                    n.cnt = q.cnt + 4'h1;
                    if (q.cnt == `MDM_LAST_ADDR) begin
                        n.cnt = 4'h0;
                        n.state = mdm_pkg::MDM_TA;
                        n.shift = 16'h0000;
                        if (q.op == `MDM_OP_READ && match) begin
                            // field indexes the words directly, except 0x0E which reads the window
                            rdata = q.regs[n.reg_addr];
                            if (n.reg_addr == `MDM_IDX_ADDR_DATA) begin
                                if (!sel_ok) begin
                                    rdata = 16'h0000;
                                end else if (fn == `MDM_FN_ADDR) begin
                                    rdata = q.ext_addr;
                                end else begin
                                    rdata = q.ext[eidx];
                                    // read side post-increment only in one mode
                                    if (fn == `MDM_FN_INC_RW) begin
                                        n.ext_addr = q.ext_addr + 16'h0001;
                                    end
                                end
                            end
                            n.shift = rdata;
                        end
                    end
                end
                // two bit turnaround
                mdm_pkg::MDM_TA: begin
                    n.cnt = q.cnt + 4'h1;
                    if (q.cnt != `MDM_LAST_TA) begin
                        // first bit left to the pull-up; zero for the second
                        if (q.op == `MDM_OP_READ && match) begin
                            n.drive = 1'b1;
                            n.out_bit = 1'b0;
                        end
                    end else begin
                        n.cnt = 4'h0;
                        n.state = mdm_pkg::MDM_DATA;
                        // first data bit goes out right after turnaround
                        if (q.drive) begin
                            n.out_bit = q.shift[15];
                            n.shift = {q.shift[14:0], 1'b0};
                        end
                    end
                end
                // sixteen data bits, MSB first
                mdm_pkg::MDM_DATA: begin
                    n.cnt = q.cnt + 4'h1;
                    if (q.op == `MDM_OP_READ) begin
                        if (q.cnt == `MDM_LAST_DATA) begin
                            n.drive = 1'b0;
                            n.out_bit = 1'b0;
                        end else if (q.drive) begin
                            n.out_bit = q.shift[15];
                            n.shift = {q.shift[14:0], 1'b0};
                        end
                    end else begin
                        // writes never enable the driver
                        n.shift = wdata;
                    end
                    if (q.cnt == `MDM_LAST_DATA) begin
                        n.cnt = 4'h0;
                        n.state = mdm_pkg::MDM_HUNT;
                        if (q.op == `MDM_OP_WRITE && match) begin
                            if (q.reg_addr == `MDM_IDX_ADDR_DATA) begin
                                // wrong target space: whole access dropped
                                if (sel_ok) begin
                                    if (fn == `MDM_FN_ADDR) begin
                                        n.ext_addr = wdata;
                                    end else begin
                                        n.ext[eidx] = wdata;
                                        if (fn != `MDM_FN_DATA) begin
                                            n.ext_addr = q.ext_addr + 16'h0001;
                                        end
                                    end
                                end
                            end else begin
                                n.regs[q.reg_addr] = wdata;
                            end
                        end
                    end
                end
                default: begin
                    n.state = mdm_pkg::MDM_HUNT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // strap caught every cycle of reset, so it settles through the
    // synchroniser; reset must be held at least three cycles
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            q.mdc_sync <= n.mdc_sync;
            q.mdio_sync <= n.mdio_sync;
            q.strap_sync <= n.strap_sync;
            q.mdc_prev <= 1'b0;
            q.phy_addr <= q.strap_sync[1];
            // a frame already under way at release is not trusted
            q.state <= mdm_pkg::MDM_HUNT;
            q.cnt <= 4'h0;
            q.op <= 2'h0;
            q.phy <= 5'h00;
            q.reg_addr <= 5'h00;
            q.shift <= 16'h0000;
            q.drive <= 1'b0;
            q.out_bit <= 1'b0;
            q.regs <= {32{`MDM_REG_RESET}};
            q.ext_addr <= `MDM_EXT_ADDR_RESET;
            q.ext <= {16{`MDM_REG_RESET}};
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // both straight from flip-flops, no glitches on the shared line
    assign mdio_o = q.out_bit;
    assign mdio_oe_o = q.drive;

endmodule // mdm_slave

// file: mdm_slave_asserts.sv
// port assertions for the serial management slave
`timescale 1ns/100ps
module mdm_slave_asserts (
    // system
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // management link
    input wire logic mdc_i,
    input wire logic mdio_i,
    input wire logic mdio_o,
    input wire logic mdio_oe_o,
    // straps
    input wire logic [2:0] phy_strap_i
);
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    logic [1:0] mdc_q;   // pin samples, one stage ahead of the design
    logic mdio_q;
    logic [14:0] hist_q; // last bits seen on clock rises
    logic [3:0] since_q; // clocks since a rise, saturates
    logic [4:0] runs_q;  // rises counted while driving
    logic [2:0] strap_q;
    logic rise;
    assign rise = mdc_q[0] & ~mdc_q[1];
    // one clocked process keeps every helper single-driven
    always_ff @(posedge clk_sys_i) begin
        mdc_q <= {mdc_q[0], mdc_i};
        mdio_q <= mdio_i;
        if (reset_i) strap_q <= phy_strap_i;
        if (rise) hist_q <= {hist_q[13:0], mdio_q};
        since_q <= reset_i ? 4'hF : rise ? 4'h0 : since_q + {3'h0, since_q != 4'hF};
        runs_q <= !mdio_oe_o ? 5'h00 : runs_q + {4'h0, rise};
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // zero turnaround bit stands well past the driving edge
    sequence s_ta_zero;
        (mdio_oe_o && !mdio_o) [*4];
    endsequence
    a_reset_quiet: assert property (@(posedge clk_sys_i) disable iff (1'h0) reset_i |=> !mdio_oe_o && !mdio_o) else $error("line driven after reset");
    a_ta_zero: assert property ($rose(mdio_oe_o) |-> s_ta_zero) else $error("turnaround not zero");
    a_read_op: assert property ($rose(mdio_oe_o) |-> hist_q[14:11] == 4'h6) else $error("drove outside read");
    a_addr_match: assert property ($rose(mdio_oe_o) |-> hist_q[10:6] == {2'h0, strap_q}) else $error("answered other address");
    a_ta_free: assert property ($rose(mdio_oe_o) |-> hist_q[0]) else $error("first turnaround driven");
    a_edge_timing: assert property ($changed(mdio_oe_o) |-> since_q inside {[0:4]}) else $error("enable moved off edge");
    a_bit_timing: assert property (mdio_oe_o && $changed(mdio_o) |-> since_q inside {[0:4]}) else $error("data moved off edge");
    a_data_length: assert property ($fell(mdio_oe_o) |-> runs_q == 5'h11) else $error("wrong driven length");
endmodule // mdm_slave_asserts

bind mdm_slave mdm_slave_asserts i_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .mdc_i(mdc_i),
    .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .phy_strap_i(phy_strap_i));

// file: mdm_station.sv
// behavioural management station driving clock and shared data line
`timescale 1ns/100ps
module mdm_station (
    // device side of the line
    input wire logic dev_out_i,
    input wire logic dev_oe_i,
    // link toward the device
    output logic mdc_o,
    output logic line_o
);
    logic sta_oe;  // station drives the line
    logic sta_d;
    logic clash_q; // sticky: two drivers at a rise
    // pull-up wins when nobody drives
    assign line_o = dev_oe_i ? dev_out_i : (sta_oe ? sta_d : 1'h1);
    initial begin
        mdc_o = 1'h0;
        sta_oe = 1'h0;
        sta_d = 1'h1;
        clash_q = 1'h0;
    end
    always @(posedge mdc_o) clash_q <= clash_q | (dev_oe_i & sta_oe);
    // one 200 ns bit; clock is stopped low between frames
    task automatic bit_t(input logic drv, input logic b, output logic s);
        sta_oe = drv;
        sta_d = b;
        #100 mdc_o = 1'h1;
        s = line_o; // sampled on the rise
        #100 mdc_o = 1'h0;
    endtask
    // idle pair, start, op, phy, reg, turnaround, data msb first
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [33:0] hdr;
        logic s;
        logic rdop;
        rdop = (op == 2'h2);
        hdr = {2'h3, 2'h1, op, phy, rg, 2'h2, wd}; // write turnaround 10
        rd = 16'h0000;
        for (int i = 33; i >= 0; i--) begin
            bit_t(!(rdop && i < 18), hdr[i], s); // released from first turnaround
            if (i < 16) rd = {rd[14:0], s};
        end
        // trailing idle bit already releases the line, so a following
        // frame never assigns the enable twice in one time step
        bit_t(1'h0, 1'h1, s);
    endtask
endmodule // mdm_station

// file: mdm_slave_test.sv
// self-checking bench for the serial management slave
`timescale 1ns/100ps
module mdm_slave_test;
    logic clk_sys_i;
    logic reset_i;
    logic [2:0] strap;
    logic mdc;
    logic line;
    logic mdio_o;
    logic oe;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [4:0] me = 5'h05; // address given by the straps
    mdm_slave i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .mdc_i(mdc), .mdio_i(line),
        .mdio_o(mdio_o), .mdio_oe_o(oe), .phy_strap_i(strap));
    mdm_station i_sta (.dev_out_i(mdio_o), .dev_oe_i(oe), .mdc_o(mdc), .line_o(line));
    initial begin
        clk_sys_i = 1'h0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // hang guard, ceiling well above the expected run
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic do_reset(input logic [2:0] s);
        #1 reset_i = 1'h1;
        strap = s;
        repeat (10) @(posedge clk_sys_i);
        #1 reset_i = 1'h0;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wr(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d);
        logic [15:0] x;
        i_sta.frame(2'h1, phy, rg, d, x);
    endtask
    task automatic rc(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] exp);
        logic [15:0] d;
        i_sta.frame(2'h2, phy, rg, 16'h0000, d);
        chk($sformatf("reg %h", rg), d, exp);
    endtask
    function automatic logic [15:0] pat(input logic [4:0] r);
        return {r, 3'h5, r, 3'h2};
    endfunction
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // every plain word: reset zero, then own pattern, msb first
    task automatic t_direct();
        for (int r = 0; r < 32; r++) begin
            if (r == 13 || r == 14) continue;
            rc(me, 5'(r), 16'h0000);
            wr(me, 5'(r), pat(5'(r)));
        end
        for (int r = 0; r < 32; r++) begin
            if (r != 13 && r != 14) rc(me, 5'(r), pat(5'(r)));
        end
    endtask
    // foreign addresses and bad op codes leave line and words alone
    task automatic t_silent();
        logic [15:0] x;
        logic [33:0] v; // raw bits of a frame with a broken start
        logic s;
        rc(5'h03, 5'h01, 16'hFFFF);
        rc(5'h0D, 5'h01, 16'hFFFF);
        wr(5'h04, 5'h01, 16'h0000);
        i_sta.frame(2'h3, me, 5'h02, 16'h0000, x);
        i_sta.frame(2'h0, me, 5'h02, 16'h0000, x);
        rc(me, 5'h01, pat(5'h01));
        rc(me, 5'h02, pat(5'h02));
        // start of 00 must be refused: the write that follows it is not taken
        v = {2'h3, 2'h0, 2'h1, me, 5'h03, 2'h2, 16'hFFFF};
        for (int i = 33; i >= 0; i--) begin
            i_sta.bit_t(1'h1, v[i], s);
        end
        i_sta.bit_t(1'h0, 1'h1, s);
        rc(me, 5'h03, pat(5'h03));
    endtask
    // all four window functions, then target space filtering
    task automatic t_indirect();
        wr(me, 5'h0D, 16'h001F);
        wr(me, 5'h0E, 16'h0002);
        wr(me, 5'h0D, 16'hC01F);
        wr(me, 5'h0E, 16'h1111);
        wr(me, 5'h0E, 16'h2222);
        rc(me, 5'h0E, 16'h0000);
        rc(me, 5'h0E, 16'h0000);
        wr(me, 5'h0D, 16'h001F);
        rc(me, 5'h0E, 16'h0004);
        wr(me, 5'h0D, 16'h0001);
        wr(me, 5'h0E, 16'h0002);
        wr(me, 5'h0D, 16'h8001);
        rc(me, 5'h0E, 16'h1111);
        rc(me, 5'h0E, 16'h2222);
        wr(me, 5'h0D, 16'h0001);
        rc(me, 5'h0E, 16'h0004);
        wr(me, 5'h0D, 16'h4001);
        wr(me, 5'h0E, 16'h3333);
        rc(me, 5'h0E, 16'h3333);
        rc(me, 5'h0E, 16'h3333);
        wr(me, 5'h0D, 16'h4002);
        rc(me, 5'h0E, 16'h0000);
        wr(me, 5'h0E, 16'h4444);
        rc(me, 5'h0D, 16'h4002);
        for (int i = 0; i < 3; i++) begin
            wr(me, 5'h0D, {11'h200, i == 0 ? 5'h03 : i == 1 ? 5'h07 : 5'h1F});
            rc(me, 5'h0E, 16'h3333);
        end
    endtask
    // new strap value taken at a second reset
    task automatic t_restrap();
        do_reset(3'h2);
        rc(5'h02, 5'h01, 16'h0000);
        rc(me, 5'h01, 16'hFFFF);
    endtask
    initial begin
        reset_i = 1'h1;
        strap = 3'h5;
        do_reset(3'h5);
        t_direct();
        t_silent();
        t_indirect();
        t_restrap();
        chk("line clash", {15'h0000, i_sta.clash_q}, 16'h0000);
        end_sim();
    end
endmodule // mdm_slave_test
